// [rta_tamper_alarm.sv]
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Overview of operation
// - codes 3..7 sample every 4096..256 periods
// - tamper-to-stamp sets stamp flag regardless enable
// - edge mode: polarity 0 rising, 1 falling
// - level mode: polarity 0 low, 1 high
// - inputs detected only while own enable set
// - irq enable gates tamper interrupt request
// - alarm sub-second writable if alarm off/init
// - backup reset clears sub-second register to zero
// - mask count zero: match every second boundary
// - mask count n compares low n bits
// - counter bit 15 never compared
// - stored value compared with prescaler counter
// - level filter needs 2, 4, 8 samples
// - codes 0..2 sample every 32768..8192 periods
// - tamper erases backup unless keep-backup set
// ------------------------------------------------------------
module rta_tamper_alarm (
    // clock and backup-domain reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire rta_pkg::rta_bus_req_type bus_req,
    output logic [31:0] bus_rdata,
    // tamper pins
    input wire logic [2:0] tamper_pin,
    // calendar side
    input wire logic [15:0] subsecond_counter,
    input wire logic second_boundary,
    input wire logic other_fields_match,
    // results
    output logic alarm0_match,
    output logic tamper_irq,
    output logic backup_erase,
    output logic stamp_flag
);
    import rta_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    rta_tamper_cfg_type tamper_cfg; // tamper configuration
    logic [31:0] alarm0_subsecond_match; // mask count and value
    logic alarm0_on; // alarm 0 enable
    logic init_mode_flag; // initialization mode
    logic stamp_enable; // timestamp enable
    logic [2:0] tamper_flag; // sticky per-input tamper flags
    logic [RTA_DIV_WIDTH-1:0] sample_div; // free divider for sampling
    logic sample_tick; // one-cycle sampling strobe
    logic [2:0] tamper_event; // per-input event pulses
    logic any_event;
    logic wr_cfg; // tamper configuration write
    logic wr_ss; // sub-second write, before protection
    logic wr_ctrl; // control write
    logic wr_stat; // status write-one-to-clear

    // decode of one offset against the request
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    assign wr_cfg = bus_req.write && hit(bus_req.addr, RTA_TAMPER_CFG_OFFSET);
    assign wr_ss = bus_req.write && hit(bus_req.addr, RTA_ALARM0_SS_OFFSET);
    assign wr_ctrl = bus_req.write && hit(bus_req.addr, RTA_CONTROL_OFFSET);
    assign wr_stat = bus_req.write && hit(bus_req.addr, RTA_STATUS_OFFSET);

    // ------------------------------------------------------------
    // tamper configuration register
    // ------------------------------------------------------------
    // software should drop the enables first; hardware does not force it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tamper_cfg <= rta_tamper_cfg_type'(RTA_TAMPER_CFG_RESET[15:0]);
        end else if (wr_cfg) begin
            tamper_cfg.detect_on <= {bus_req.wdata[RTA_TAMPER2_DETECT_ON_BIT],
                                     bus_req.wdata[RTA_TAMPER1_DETECT_ON_BIT],
                                     bus_req.wdata[RTA_TAMPER0_DETECT_ON_BIT]};
            tamper_cfg.polarity <= {bus_req.wdata[RTA_TAMPER2_POLARITY_BIT],
                                    bus_req.wdata[RTA_TAMPER1_POLARITY_BIT],
                                    bus_req.wdata[RTA_TAMPER0_POLARITY_BIT]};
            tamper_cfg.irq_on <= bus_req.wdata[RTA_TAMPER_IRQ_ON_BIT];
            tamper_cfg.tamper_to_stamp <= bus_req.wdata[RTA_TAMPER_TO_STAMP_BIT];
            tamper_cfg.sample_rate <= bus_req.wdata[RTA_SAMPLE_RATE_LSB +: 3];
            tamper_cfg.filter_setting <= bus_req.wdata[RTA_FILTER_LSB +: 2];
            tamper_cfg.keep_backup <= bus_req.wdata[RTA_KEEP_BACKUP_LSB +: 3];
        end
    end

    // ------------------------------------------------------------
    // control register: alarm enable, init mode, stamp enable
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm0_on <= 1'b0;
            init_mode_flag <= 1'b0;
            stamp_enable <= 1'b0;
        end else if (wr_ctrl) begin
            alarm0_on <= bus_req.wdata[RTA_CTRL_ALARM0_ON_BIT];
            init_mode_flag <= bus_req.wdata[RTA_CTRL_INIT_MODE_BIT];
            stamp_enable <= bus_req.wdata[RTA_CTRL_STAMP_ENABLE_BIT];
        end
    end

    // ------------------------------------------------------------
    // alarm 0 sub-second register; reset_n is the backup-domain reset
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            alarm0_subsecond_match <= RTA_ALARM0_SS_RESET;
        end else if (wr_ss && (!alarm0_on || init_mode_flag)) begin
            // reserved bits are dropped, so they always read zero
            alarm0_subsecond_match <= bus_req.wdata & RTA_ALARM0_SS_WMASK;
        end
    end

    // ------------------------------------------------------------
    // sub-second comparison
    // ------------------------------------------------------------
    logic [3:0] mask_count;
    logic [14:0] cmp_mask;
    logic ss_equal;
    assign mask_count = alarm0_subsecond_match[RTA_MASK_COUNT_LSB +: 4];
    // low n bits only; the counter's top bit is never looked at
    assign cmp_mask = 15'((16'h0001 << mask_count) - 16'h0001);
    assign ss_equal = ((subsecond_counter[14:0] ^ alarm0_subsecond_match[14:0]) & cmp_mask) == 15'h0000;

    // count 0 means nothing is compared: fire at the second boundary
    always_comb begin
        if (mask_count == 4'h0) begin
            alarm0_match = other_fields_match && second_boundary;
        end else begin
            alarm0_match = other_fields_match && ss_equal;
        end
    end

    // ------------------------------------------------------------
    // sampling divider on the rtc tick clock
    // ------------------------------------------------------------
    logic [RTA_DIV_WIDTH-1:0] div_mask;
    // code c gives 2^(15-c) periods: 32768 .. 256
    assign div_mask = RTA_DIV_WIDTH'((16'h8000 >> tamper_cfg.sample_rate) - 16'h0001);
    assign sample_tick = (sample_div & div_mask) == div_mask;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sample_div <= '0;
        end else begin
            sample_div <= sample_div + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // per-input detectors
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            rta_tamper_channel u_chan (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .detect_on(tamper_cfg.detect_on[gi]),
                .polarity(tamper_cfg.polarity[gi]),
                .filter_setting(tamper_cfg.filter_setting),
                .sample_tick(sample_tick),
                .tamper_pin(tamper_pin[gi]),
                .event_pulse(tamper_event[gi])
            );
        end
    endgenerate
    assign any_event = |tamper_event;

    // ------------------------------------------------------------
    // sticky flags; an event in the clearing cycle wins
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tamper_flag <= 3'h0;
        end else begin
            tamper_flag <= (wr_stat ? (tamper_flag & ~bus_req.wdata[RTA_STAT_TAMPER_LSB +: 3]) : tamper_flag)
                           | tamper_event;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stamp_flag <= 1'b0;
        end else if (any_event && (tamper_cfg.tamper_to_stamp || stamp_enable)) begin
            stamp_flag <= 1'b1;
        end else if (wr_stat && bus_req.wdata[RTA_STAT_STAMP_FLAG_BIT]) begin
            stamp_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // interrupt and backup erase
    // ------------------------------------------------------------
    assign tamper_irq = tamper_cfg.irq_on && (|tamper_flag);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            backup_erase <= 1'b0;
        end else begin
            backup_erase <= |(tamper_event & ~tamper_cfg.keep_backup);
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe; unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_rdata <= 32'h0000_0000;
        end else if (bus_req.read) begin
            bus_rdata <= 32'h0000_0000;
            unique case (1'b1)
                hit(bus_req.addr, RTA_TAMPER_CFG_OFFSET): begin
                    bus_rdata[RTA_TAMPER0_DETECT_ON_BIT] <= tamper_cfg.detect_on[0];
                    bus_rdata[RTA_TAMPER1_DETECT_ON_BIT] <= tamper_cfg.detect_on[1];
                    bus_rdata[RTA_TAMPER2_DETECT_ON_BIT] <= tamper_cfg.detect_on[2];
                    bus_rdata[RTA_TAMPER0_POLARITY_BIT] <= tamper_cfg.polarity[0];
                    bus_rdata[RTA_TAMPER1_POLARITY_BIT] <= tamper_cfg.polarity[1];
                    bus_rdata[RTA_TAMPER2_POLARITY_BIT] <= tamper_cfg.polarity[2];
                    bus_rdata[RTA_TAMPER_IRQ_ON_BIT] <= tamper_cfg.irq_on;
                    bus_rdata[RTA_TAMPER_TO_STAMP_BIT] <= tamper_cfg.tamper_to_stamp;
                    bus_rdata[RTA_SAMPLE_RATE_LSB +: 3] <= tamper_cfg.sample_rate;
                    bus_rdata[RTA_FILTER_LSB +: 2] <= tamper_cfg.filter_setting;
                    bus_rdata[RTA_KEEP_BACKUP_LSB +: 3] <= tamper_cfg.keep_backup;
                end
                hit(bus_req.addr, RTA_ALARM0_SS_OFFSET): begin
                    bus_rdata <= alarm0_subsecond_match;
                end
                hit(bus_req.addr, RTA_CONTROL_OFFSET): begin
                    bus_rdata[RTA_CTRL_ALARM0_ON_BIT] <= alarm0_on;
                    bus_rdata[RTA_CTRL_INIT_MODE_BIT] <= init_mode_flag;
                    bus_rdata[RTA_CTRL_STAMP_ENABLE_BIT] <= stamp_enable;
                end
                hit(bus_req.addr, RTA_STATUS_OFFSET): begin
                    bus_rdata[RTA_STAT_TAMPER_LSB +: 3] <= tamper_flag;
                    bus_rdata[RTA_STAT_STAMP_FLAG_BIT] <= stamp_flag;
                end
                default: begin
                    bus_rdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // sub-second register: writable only while the alarm is off or in init
    sequence ss_locked_write;
        wr_ss && alarm0_on && !init_mode_flag;
    endsequence

    protected_write_a: assert property (ss_locked_write |=> $stable(alarm0_subsecond_match))
        else $error("protected sub-second register changed");

    open_write_a: assert property (wr_ss && !alarm0_on |=>
        alarm0_subsecond_match == ($past(bus_req.wdata) & RTA_ALARM0_SS_WMASK))
        else $error("open sub-second write lost");

    // comparison, restated without the design's own mask
    mask_zero_a: assert property (mask_count == 4'h0 && other_fields_match |->
        alarm0_match == second_boundary)
        else $error("masked match not on second boundary");

    top_bit_a: assert property ($changed(subsecond_counter[15]) && $stable(subsecond_counter[14:0])
        && $stable(alarm0_subsecond_match) && mask_count != 4'h0 && $stable(other_fields_match)
        |-> $stable(alarm0_match))
        else $error("counter top bit affected match");

    low_bits_a: assert property (mask_count != 4'h0 && other_fields_match |->
        alarm0_match == ((({17'h0, subsecond_counter[14:0]} ^ {17'h0, alarm0_subsecond_match[14:0]})
        << (32 - mask_count)) == 32'h0000_0000))
        else $error("sub-second compare width wrong");

    // tamper side: stamp link, interrupt gate, enables, erase
    stamp_link_a: assert property (any_event && tamper_cfg.tamper_to_stamp |=> stamp_flag)
        else $error("stamp flag missed on tamper");

    stamp_enable_a: assert property (any_event && stamp_enable |=> stamp_flag)
        else $error("stamp flag missed with stamp enable");

    stamp_quiet_a: assert property (any_event && !tamper_cfg.tamper_to_stamp && !stamp_enable && !stamp_flag
        |=> !stamp_flag)
        else $error("stamp flag set with link off");

    irq_gate_a: assert property (!tamper_cfg.irq_on |-> !tamper_irq)
        else $error("interrupt not gated");

    disabled_quiet_a: assert property (!tamper_cfg.detect_on[0] |-> !tamper_event[0])
        else $error("disabled input reported event");

    erase_keep_a: assert property (tamper_event[2] && !tamper_cfg.keep_backup[2] |=> backup_erase)
        else $error("backup erase missing");

    erase_quiet_a: assert property (tamper_event == 3'b001 && tamper_cfg.keep_backup[0] |=> !backup_erase)
        else $error("kept input erased backup");

    // edge mode on input 0, both polarities
    sequence rise_seen0;
        tamper_cfg.detect_on[0] && tamper_cfg.filter_setting == 2'h0 && !tamper_cfg.polarity[0]
        && $rose(tamper_pin[0]);
    endsequence

    sequence fall_seen0;
        tamper_cfg.detect_on[0] && tamper_cfg.filter_setting == 2'h0 && tamper_cfg.polarity[0]
        && $fell(tamper_pin[0]);
    endsequence

    edge_rise_a: assert property (rise_seen0 |-> tamper_event[0])
        else $error("rising edge not detected");
    edge_fall_a: assert property (fall_seen0 |-> tamper_event[0])
        else $error("falling edge not detected");

    // level mode decides only on sample ticks
    level_tick_a: assert property (tamper_cfg.filter_setting != 2'h0 && !sample_tick |-> tamper_event == 3'h0)
        else $error("level event off the sample tick");

    // sampling interval
    tick_rate_a: assert property (sample_tick && tamper_cfg.sample_rate == 3'h7 && !wr_cfg |->
        ##1 (!sample_tick) [*8])
        else $error("sample tick too frequent");

endmodule : rta_tamper_alarm
`default_nettype wire

// [rta_pkg.sv]
package rta_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] RTA_TAMPER_CFG_OFFSET = 8'h40;  // tamper configuration word
    localparam logic [7:0] RTA_ALARM0_SS_OFFSET = 8'h44;   // alarm 0 sub-second match
    localparam logic [7:0] RTA_STATUS_OFFSET = 8'h4c;      // tamper and stamp status
    localparam logic [7:0] RTA_CONTROL_OFFSET = 8'h3c;     // alarm enable, init mode, stamp enable

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RTA_ALARM0_SS_RESET = 32'h0000_0000;
    localparam logic [31:0] RTA_TAMPER_CFG_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // tamper configuration field positions
    // ------------------------------------------------------------
    localparam int RTA_TAMPER0_DETECT_ON_BIT = 0;
    localparam int RTA_TAMPER0_POLARITY_BIT = 1;
    localparam int RTA_TAMPER_IRQ_ON_BIT = 2;
    localparam int RTA_TAMPER1_DETECT_ON_BIT = 3;
    localparam int RTA_TAMPER1_POLARITY_BIT = 4;
    localparam int RTA_TAMPER2_DETECT_ON_BIT = 5;
    localparam int RTA_TAMPER2_POLARITY_BIT = 6;
    localparam int RTA_TAMPER_TO_STAMP_BIT = 7;
    localparam int RTA_SAMPLE_RATE_LSB = 8;
    localparam int RTA_FILTER_LSB = 11;
    localparam int RTA_KEEP_BACKUP_LSB = 19;

    // ------------------------------------------------------------
    // control / status field positions
    // ------------------------------------------------------------
    localparam int RTA_CTRL_ALARM0_ON_BIT = 0;
    localparam int RTA_CTRL_INIT_MODE_BIT = 1;
    localparam int RTA_CTRL_STAMP_ENABLE_BIT = 2;
    localparam int RTA_STAT_TAMPER_LSB = 0;
    localparam int RTA_STAT_STAMP_FLAG_BIT = 4;

    // ------------------------------------------------------------
    // sub-second match layout
    // ------------------------------------------------------------
    localparam int RTA_MASK_COUNT_LSB = 24;
    localparam int RTA_SS_VALUE_WIDTH = 15;
    localparam logic [31:0] RTA_ALARM0_SS_WMASK = 32'h0f00_7fff;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int RTA_SAMPLE_SHIFT_MAX = 15;              // code 0 = 2^15 periods
    localparam int RTA_DIV_WIDTH = 15;

    // the tamper configuration fields as one carrier
    typedef struct packed {
        logic [2:0] keep_backup;
        logic [1:0] filter_setting;
        logic [2:0] sample_rate;
        logic tamper_to_stamp;
        logic [2:0] polarity;
        logic [2:0] detect_on;
        logic irq_on;
    } rta_tamper_cfg_type;

    // the register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic write;
        logic read;
    } rta_bus_req_type;

endpackage : rta_pkg

// [rta_tamper_channel.sv]
`timescale 1ns/1ps
`default_nettype none

// one tamper input: edge detect or level filter on the sample tick
module rta_tamper_channel (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // configuration
    input wire logic detect_on,
    input wire logic polarity,
    input wire logic [1:0] filter_setting,
    input wire logic sample_tick,
    // pin and result
    input wire logic tamper_pin,
    output logic event_pulse
);
    import rta_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic prev_level;      // last pin level seen, for edge mode
    logic [3:0] run_count; // consecutive active samples, level mode
    logic [3:0] need;      // samples required by the filter
    logic active_level;

    assign need = 4'h1 << filter_setting;
    // polarity 1 selects high level in level mode
    assign active_level = (tamper_pin == polarity);

    // ------------------------------------------------------------
    // edge history, tracked every cycle so a fresh enable sees no false edge
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= tamper_pin;
        end
    end

    // ------------------------------------------------------------
    // level filter counter, advanced only on sample ticks
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_count <= 4'h0;
        end else if (!detect_on || filter_setting == 2'h0) begin
            run_count <= 4'h0;
        end else if (sample_tick) begin
            if (!active_level) begin
                run_count <= 4'h0;
            end else if (run_count < need) begin
                run_count <= run_count + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // event decision; only while enabled
    // ------------------------------------------------------------
    always_comb begin
        event_pulse = 1'b0;
        if (detect_on) begin
            if (filter_setting == 2'h0) begin
                // 0 picks rising, 1 picks falling
                event_pulse = polarity ? (prev_level && !tamper_pin)
                                       : (!prev_level && tamper_pin);
            end else begin
                // fires once when the run reaches the required length
                event_pulse = sample_tick && active_level && (run_count == need - 4'h1);
            end
        end
    end

endmodule : rta_tamper_channel
`default_nettype wire

// [rta_tamper_switch.sv]
`timescale 1ns/1ps
`default_nettype none

// tamper switch contacts wired to the three tamper pins
module rta_tamper_switch (
    // clock
    input wire logic sys_clk,
    // contact command from the bench
    input wire logic [2:0] close_cmd,
    input wire logic slow,
    // pins seen by the device
    output logic [2:0] tamper_pin
);
    logic [2:0] stage = 3'h0; // extra contact delay for slow switches
    initial tamper_pin = 3'h0;

    // ------------------------------------------------------------
    // contacts settle one or two cycles after the command
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        stage <= close_cmd;
        tamper_pin <= slow ? stage : close_cmd;
    end
endmodule : rta_tamper_switch

`default_nettype wire

// [rta_tamper_alarm_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module rta_tamper_alarm_tb;
    import rta_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    rta_bus_req_type bus_req = '0;
    logic [31:0] bus_rdata;
    logic [2:0] close_cmd = 3'h0;
    logic slow = 1'b0;
    logic [2:0] tamper_pin;
    logic [15:0] subsecond_counter = 16'h0000;
    logic second_boundary = 1'b0;
    logic other_fields_match = 1'b0;
    logic alarm0_match, tamper_irq, backup_erase, stamp_flag;
    logic erase_seen = 1'b0; // sticky copy of the one-cycle erase pulse
    int error_cnt = 0;
    int checks_done = 0;

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (backup_erase === 1'b1) erase_seen <= 1'b1;

    rta_tamper_switch rta_tamper_switch_i (.sys_clk(sys_clk), .close_cmd(close_cmd), .slow(slow),
        .tamper_pin(tamper_pin));
    rta_tamper_alarm rta_tamper_alarm_i (.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .tamper_pin(tamper_pin), .subsecond_counter(subsecond_counter),
        .second_boundary(second_boundary), .other_fields_match(other_fields_match),
        .alarm0_match(alarm0_match), .tamper_irq(tamper_irq), .backup_erase(backup_erase),
        .stamp_flag(stamp_flag));

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // full-word accesses only; strobe lasts one cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, write: 1'b1, read: 1'b0};
        @(posedge sys_clk);
        bus_req.write <= 1'b0;
    endtask : wr

    // read data appear in the cycle after the strobe edge and hold until the next read
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 32'h0, write: 1'b0, read: 1'b1};
        @(posedge sys_clk);
        bus_req.read <= 1'b0;
        @(negedge sys_clk);
        chk(what, exp, bus_rdata);
    endtask : rdchk

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        rdchk("ss reset", 8'h44, 32'h0000_0000);
        wr(8'h44, 32'h0a00_1234);
        rdchk("ss value", 8'h44, 32'h0a00_1234);
        rdchk("unmapped", 8'h10, 32'h0000_0000);
        $display("test regs done");
    endtask : t_regs

    task automatic t_protect;
        wr(8'h3c, 32'h0000_0001); // alarm on, init off: locked
        wr(8'h44, 32'h0300_0007);
        rdchk("ss locked", 8'h44, 32'h0a00_1234);
        wr(8'h3c, 32'h0000_0003); // init mode reopens it
        rdchk("ctrl", 8'h3c, 32'h0000_0003);
        wr(8'h44, 32'h0300_0007);
        rdchk("ss init", 8'h44, 32'h0300_0007);
        wr(8'h3c, 32'h0000_0000);
        $display("test protect done");
    endtask : t_protect

    task automatic t_match;
        logic [15:0] c;
        other_fields_match <= 1'b1;
        wr(8'h44, 32'h0000_0155);
        second_boundary <= 1'b1;
        @(negedge sys_clk);
        chk("mask0 hit", 32'h1, {31'h0, alarm0_match});
        @(posedge sys_clk);
        second_boundary <= 1'b0;
        @(negedge sys_clk);
        chk("mask0 idle", 32'h0, {31'h0, alarm0_match});
        // mask counts 1 to 15; bit 15 and bits above the window disagree
        for (int n = 1; n < 16; n++) begin
            wr(8'h44, {4'h0, n[3:0], 9'h0, 15'h7fff});
            c = 16'h8000 | 16'((1 << n) - 1);
            subsecond_counter <= c;
            @(negedge sys_clk);
            chk("mask hit", 32'h1, {31'h0, alarm0_match});
            @(posedge sys_clk);
            subsecond_counter <= c & 16'h7fff;
            @(negedge sys_clk);
            chk("top bit", 32'h1, {31'h0, alarm0_match});
            @(posedge sys_clk);
            subsecond_counter <= c ^ 16'(1 << (n - 1));
            @(negedge sys_clk);
            chk("mask miss", 32'h0, {31'h0, alarm0_match});
        end
        $display("test match done");
    endtask : t_match

    task automatic t_edge;
        wr(8'h40, 32'h0000_0005); // input 0 rising, irq on
        close_cmd <= 3'b001;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("rise irq", 32'h1, {31'h0, tamper_irq});
        chk("erase", 32'h1, {31'h0, erase_seen});
        chk("no stamp", 32'h0, {31'h0, stamp_flag});
        wr(8'h40, 32'h0000_0000);
        wr(8'h4c, 32'h0000_0017);
        erase_seen <= 1'b0;
        wr(8'h40, 32'h0008_0083); // falling, stamp link, keep backup, irq off
        close_cmd <= 3'b000;
        repeat (5) @(posedge sys_clk);
        rdchk("fall status", 8'h4c, 32'h0000_0011);
        chk("irq off", 32'h0, {31'h0, tamper_irq});
        chk("kept", 32'h0, {31'h0, erase_seen});
        wr(8'h40, 32'h0000_0000);
        wr(8'h4c, 32'h0000_0017);
        wr(8'h40, 32'h0000_0005); // input 1 left disabled
        close_cmd <= 3'b010;
        repeat (5) @(posedge sys_clk);
        rdchk("disabled", 8'h4c, 32'h0000_0000);
        $display("test edge done");
    endtask : t_edge

    task automatic t_level;
        int n;
        wr(8'h40, 32'h0000_0000);
        slow <= 1'b1;
        close_cmd <= 3'b000;
        wr(8'h3c, 32'h0000_0004); // stamp enable on, link off
        wr(8'h40, 32'h0000_0f07); // high level, two samples, every 256 cycles
        close_cmd <= 3'b001;
        n = 0;
        while (tamper_irq !== 1'b1 && n < 1200) begin
            @(negedge sys_clk);
            n++;
        end
        chk("level delay", 32'h1, {31'h0, n >= 256 && n <= 600});
        chk("stamp on", 32'h1, {31'h0, stamp_flag});
        $display("test level done");
    endtask : t_level

    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_regs();
        t_protect();
        t_match();
        t_edge();
        t_level();
        end_sim();
    end

    // tests need well under two thousand cycles; allow twenty thousand
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end
endmodule : rta_tamper_alarm_tb

`default_nettype wire
